// >>> hdl/ivm_pkg.sv
// Constants shared by the interrupt vector map
package ivm_pkg;

  localparam int unsigned VEC_W     = 8;
  localparam int unsigned LVL_W     = 5;
  localparam int unsigned ADDR_W    = 32;
  localparam int unsigned NUM_SLOTS = 48;

  // Fixed vector numbers
  localparam logic [7:0] VEC_RESET         = 8'h00;
  localparam logic [7:0] VEC_MODE          = 8'h01;
  localparam logic [7:0] VEC_SYS_RSVD_LO   = 8'h02;
  localparam logic [7:0] VEC_SYS_RSVD_HI   = 8'h06;
  localparam logic [7:0] VEC_COPRO_ABSENT  = 8'h07;
  localparam logic [7:0] VEC_COPRO_ERROR   = 8'h08;
  localparam logic [7:0] VEC_EMU_TRAP      = 8'h09;
  localparam logic [7:0] VEC_INSN_BREAK    = 8'h0A;
  localparam logic [7:0] VEC_OPERAND_BREAK = 8'h0B;
  localparam logic [7:0] VEC_STEP_TRACE    = 8'h0C;
  localparam logic [7:0] VEC_TOOL_NMI      = 8'h0D;
  localparam logic [7:0] VEC_UNDEF_INSN    = 8'h0E;
  localparam logic [7:0] VEC_USER_NMI      = 8'h0F;
  localparam logic [7:0] VEC_SLOT_BASE     = 8'h10;
  localparam logic [7:0] VEC_SLOT_LAST     = 8'h3F;
  localparam logic [7:0] VEC_RTOS_0        = 8'h40;
  localparam logic [7:0] VEC_RTOS_1        = 8'h41;
  localparam logic [7:0] VEC_RSVD_C_HI     = 8'h4F;
  localparam logic [7:0] VEC_SW_ONLY_LO    = 8'h50;

  // Level-control slot of each source group (vector = slot base + slot)
  localparam int unsigned SLOT_EXT_IRQ0    = 0;
  localparam int unsigned SLOT_RELOAD_TMR0 = 8;
  localparam int unsigned SLOT_SER_RX0     = 11;
  localparam int unsigned SLOT_SER_TX0     = 14;
  localparam int unsigned SLOT_DMA0        = 17;
  localparam int unsigned SLOT_ADC         = 22;
  localparam int unsigned SLOT_I2C         = 23;
  localparam int unsigned SLOT_RSVD_A_LO   = 24;
  localparam int unsigned SLOT_RSVD_A_HI   = 27;
  localparam int unsigned SLOT_BAUD_TMR0   = 28;
  localparam int unsigned SLOT_TIMEBASE    = 31;
  localparam int unsigned SLOT_RSVD_B_LO   = 32;
  localparam int unsigned SLOT_RSVD_B_HI   = 46;
  localparam int unsigned SLOT_DELAYED     = 47;

  // Levels
  localparam logic [4:0] LVL_USER_NMI  = 5'h0F;
  localparam logic [4:0] LVL_DISABLED  = 5'h1F;
  localparam logic [0:0] LVL_SLOT_MSB  = 1'h1;

  // Vector table geometry
  localparam logic [31:0] TBL_TOP_OFS       = 32'h0000_03FC;
  localparam logic [31:0] VEC_TBL_BASE_RST  = 32'h000F_FC00;
  localparam logic [31:0] RESET_FETCH_ADDR  = 32'h000F_FFFC;

endpackage

// >>> hdl/ivm_fetch_addr.sv
// Vector table entry address calculator, registered output
module ivm_fetch_addr #(
  parameter int unsigned ADDR_W = 32,
  parameter int unsigned VEC_W  = 8
) (
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  input  wire logic [ADDR_W-1:0] base_i,
  input  wire logic [VEC_W-1:0]  vec_i,
  output logic      [ADDR_W-1:0] addr_o
);

  logic [ADDR_W-1:0] addr_ff;
  logic [ADDR_W-1:0] nxt_addr;
  logic [ADDR_W-1:0] vec_ofs;

  always_comb begin
    vec_ofs  = {{(ADDR_W-VEC_W-2){1'b0}}, vec_i, 2'b00};
    nxt_addr = ADDR_W'(base_i + ADDR_W'(ivm_pkg::TBL_TOP_OFS) - vec_ofs);
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      addr_ff <= ADDR_W'(ivm_pkg::RESET_FETCH_ADDR);
    end else begin
      addr_ff <= nxt_addr;
    end
  end

  assign addr_o = addr_ff;

endmodule

// >>> hdl/ivm_top.sv
// Interrupt vector map: source to vector and level, winner to core
//
// Functional notes
// - Reset is vector 0, entry 3FC, no level
// - Mode vector is 1 at 3F8, no level
// - Vectors 2 to 6 reserved, never raised
// - Core exceptions use fixed vectors 7 to 14
// - User NMI is vector 15, level 15
// - External inputs 0-7 map to 16-23
// - Reload timers 0-2 map to 24-26
// - Serial receive 27-29, transmit 30-32
// - DMA channels 0-4 map to 33-37
// - Converter is 38, bus interface is 39
// - Vectors 40-43 reserved, keep their slots
// - Baud interval timers map to 44-46
// - Time base overflow is vector 47
// - Vectors 48-62 reserved, slots 32-46
// - Delayed source bit is vector 63
// - Vectors 64-79 reserved, no level slot
// - Vectors 80-255 software interrupt only
// - Entry address is base plus 3FC minus 4n
module ivm_top #(
  parameter int unsigned NUM_SLOTS = 48,
  parameter int unsigned LVL_W     = 5,
  parameter int unsigned VEC_W     = 8,
  parameter int unsigned ADDR_W    = 32
) (
  input  wire logic                       mclk_i,
  input  wire logic                       rst_i,
  input  wire logic [ADDR_W-1:0]          vector_table_base_i,
  input  wire logic                       nmi_req_i,
  input  wire logic [NUM_SLOTS-1:0]       src_req_i,
  input  wire logic [NUM_SLOTS*LVL_W-1:0] level_slot_i,
  input  wire logic [VEC_W-1:0]           vec_sel_i,
  output logic                            irq_valid_o,
  output logic      [VEC_W-1:0]           irq_vector_o,
  output logic      [LVL_W-1:0]           irq_level_o,
  output logic      [ADDR_W-1:0]          vec_fetch_addr_o,
  output logic                            vec_hw_o,
  output logic                            vec_has_slot_o
);

  logic [NUM_SLOTS-1:0]   slot_hw;
  logic [NUM_SLOTS-1:0]   eff_req;
  logic [LVL_W-1:0]       eff_lvl [NUM_SLOTS];

  logic                   irq_valid_ff;
  logic [VEC_W-1:0]       irq_vector_ff;
  logic [LVL_W-1:0]       irq_level_ff;
  logic                   vec_hw_ff;
  logic                   vec_has_slot_ff;

  logic                   nxt_irq_valid;
  logic [VEC_W-1:0]       nxt_irq_vector;
  logic [LVL_W-1:0]       nxt_irq_level;
  logic                   nxt_vec_hw;
  logic                   nxt_vec_has_slot;
  logic [5:0]             sel_slot;

  // Per-slot qualification; reserved slots keep a level but no source
  for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_slot
    assign slot_hw[s] = !((s >= ivm_pkg::SLOT_RSVD_A_LO) && (s <= ivm_pkg::SLOT_RSVD_A_HI)) &&
                        !((s >= ivm_pkg::SLOT_RSVD_B_LO) && (s <= ivm_pkg::SLOT_RSVD_B_HI));
    assign eff_req[s] = src_req_i[s] & slot_hw[s];
    // Top level bit is fixed high, so a slot never outranks NMI
    assign eff_lvl[s] = {ivm_pkg::LVL_SLOT_MSB, level_slot_i[s*LVL_W +: LVL_W-1]};
  end

  // Winner: NMI first, then lowest level, ties to lowest vector.
  // Level all-ones means disabled and never wins.
  always_comb begin
    nxt_irq_valid  = 1'b0;
    nxt_irq_vector = ivm_pkg::VEC_RESET;
    nxt_irq_level  = ivm_pkg::LVL_DISABLED;
    if (nmi_req_i) begin
      nxt_irq_valid  = 1'b1;
      nxt_irq_vector = ivm_pkg::VEC_USER_NMI;
      nxt_irq_level  = ivm_pkg::LVL_USER_NMI;
    end else begin
      for (int s = 0; s < NUM_SLOTS; s++) begin
        if (eff_req[s] && (eff_lvl[s] < nxt_irq_level)) begin
          nxt_irq_valid  = 1'b1;
          nxt_irq_vector = VEC_W'(ivm_pkg::VEC_SLOT_BASE + VEC_W'(s));
          nxt_irq_level  = eff_lvl[s];
        end
      end
    end
  end

  // Classification of the looked-up vector number
  always_comb begin
    sel_slot         = 6'(vec_sel_i - ivm_pkg::VEC_SLOT_BASE);
    nxt_vec_has_slot = (vec_sel_i >= ivm_pkg::VEC_SLOT_BASE) &&
                       (vec_sel_i <= ivm_pkg::VEC_SLOT_LAST);
    nxt_vec_hw = (vec_sel_i == ivm_pkg::VEC_USER_NMI) ||
                 (nxt_vec_has_slot && slot_hw[sel_slot]);
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      irq_valid_ff    <= 1'b0;
      irq_vector_ff   <= ivm_pkg::VEC_RESET;
      irq_level_ff    <= ivm_pkg::LVL_DISABLED;
      vec_hw_ff       <= 1'b0;
      vec_has_slot_ff <= 1'b0;
    end else begin
      irq_valid_ff    <= nxt_irq_valid;
      irq_vector_ff   <= nxt_irq_vector;
      irq_level_ff    <= nxt_irq_level;
      vec_hw_ff       <= nxt_vec_hw;
      vec_has_slot_ff <= nxt_vec_has_slot;
    end
  end

  ivm_fetch_addr #(
    .ADDR_W (ADDR_W),
    .VEC_W  (VEC_W)
  ) u_fetch_addr (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .base_i (vector_table_base_i),
    .vec_i  (vec_sel_i),
    .addr_o (vec_fetch_addr_o)
  );

  assign irq_valid_o    = irq_valid_ff;
  assign irq_vector_o   = irq_vector_ff;
  assign irq_level_o    = irq_level_ff;
  assign vec_hw_o       = vec_hw_ff;
  assign vec_has_slot_o = vec_has_slot_ff;

  // Assertion helpers only
  logic [NUM_SLOTS-1:0] req_hist_ff;
  logic [5:0]           win_slot;
  always_ff @(posedge mclk_i) begin
    req_hist_ff <= src_req_i;
  end
  assign win_slot = 6'(irq_vector_o - ivm_pkg::VEC_SLOT_BASE);

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence seq_nmi_raised;
    nmi_req_i;
  endsequence
  sequence seq_nmi_shown;
    irq_valid_o && (irq_vector_o == 8'h0F) && (irq_level_o == 5'h0F);
  endsequence

  chk_nmi_code: assert property (seq_nmi_raised |=> seq_nmi_shown)
    else $error("NMI not presented as vector 15 level 15");

  chk_slot_vector: assert property (
    irq_valid_o && (irq_vector_o != 8'h0F) |->
      (irq_vector_o >= 8'h10) && (irq_vector_o <= 8'h3F) && req_hist_ff[win_slot])
    else $error("Presented vector has no matching request");

  chk_rsvd_a_quiet: assert property (
    irq_valid_o |-> !((irq_vector_o >= 8'h28) && (irq_vector_o <= 8'h2B)))
    else $error("Reserved vector 40-43 raised");

  chk_rsvd_b_quiet: assert property (
    irq_valid_o |-> !((irq_vector_o >= 8'h30) && (irq_vector_o <= 8'h3E)))
    else $error("Reserved vector 48-62 raised");

  chk_low_quiet: assert property (
    irq_valid_o |-> (irq_vector_o >= 8'h0F) && (irq_vector_o < 8'h40))
    else $error("Vector outside hardware range raised");

  chk_idle_none: assert property (
    (!nmi_req_i && (src_req_i == '0)) |=> !irq_valid_o)
    else $error("Request shown with no source");

  chk_reset_entry: assert property (
    (vec_sel_i == 8'h00) |=> vec_fetch_addr_o == $past(vector_table_base_i) + 32'h3FC)
    else $error("Reset entry address wrong");

  chk_mode_entry: assert property (
    (vec_sel_i == 8'h01) |=> vec_fetch_addr_o == $past(vector_table_base_i) + 32'h3F8)
    else $error("Mode entry address wrong");

  chk_dflt_timer1: assert property (
    (vector_table_base_i == 32'h000F_FC00) && (vec_sel_i == 8'h19) |=>
      vec_fetch_addr_o == 32'h000F_FF98)
    else $error("Vector 25 default address wrong");

  chk_dflt_top: assert property (
    (vector_table_base_i == 32'h000F_FC00) && (vec_sel_i == 8'hFF) |=>
      vec_fetch_addr_o == 32'h000F_FC00)
    else $error("Vector 255 default address wrong");

  chk_sw_only: assert property (
    ((vec_sel_i >= 8'h40) || (vec_sel_i <= 8'h0E)) |=> !vec_hw_o && !vec_has_slot_o)
    else $error("Reserved or software vector marked hardware");

  chk_exc_fixed: assert property (
    (vec_sel_i >= 8'h02) && (vec_sel_i <= 8'h0E) |=> !vec_hw_o)
    else $error("Core exception vector marked hardware");

  // Lookup classes, one registered cycle behind the selector
  sequence seq_lookup_source;
    vec_hw_o && vec_has_slot_o;
  endsequence
  sequence seq_lookup_rsvd_slot;
    !vec_hw_o && vec_has_slot_o;
  endsequence
  sequence seq_lookup_none;
    !vec_hw_o && !vec_has_slot_o;
  endsequence

  chk_rsvd_sys_idle: assert property (
    (vec_sel_i >= 8'h02) && (vec_sel_i <= 8'h06) |=> seq_lookup_none)
    else $error("System reserved vector 2-6 marked hardware");

  chk_nmi_lookup: assert property (
    (vec_sel_i == 8'h0F) |=> vec_hw_o && !vec_has_slot_o)
    else $error("NMI vector lookup class wrong");

  chk_ext_lookup: assert property (
    (vec_sel_i >= 8'h10) && (vec_sel_i <= 8'h17) |=> seq_lookup_source)
    else $error("External input vector lookup class wrong");

  chk_tmr_lookup: assert property (
    (vec_sel_i >= 8'h18) && (vec_sel_i <= 8'h1A) |=> seq_lookup_source)
    else $error("Reload timer vector lookup class wrong");

  chk_ser_lookup: assert property (
    (vec_sel_i >= 8'h1B) && (vec_sel_i <= 8'h20) |=> seq_lookup_source)
    else $error("Serial vector lookup class wrong");

  chk_dma_lookup: assert property (
    (vec_sel_i >= 8'h21) && (vec_sel_i <= 8'h25) |=> seq_lookup_source)
    else $error("DMA vector lookup class wrong");

  chk_conv_lookup: assert property (
    (vec_sel_i >= 8'h26) && (vec_sel_i <= 8'h27) |=> seq_lookup_source)
    else $error("Converter or bus vector lookup class wrong");

  chk_rsvd_a_slot: assert property (
    (vec_sel_i >= 8'h28) && (vec_sel_i <= 8'h2B) |=> seq_lookup_rsvd_slot)
    else $error("Reserved vector 40-43 lookup class wrong");

  chk_baud_lookup: assert property (
    (vec_sel_i >= 8'h2C) && (vec_sel_i <= 8'h2E) |=> seq_lookup_source)
    else $error("Baud timer vector lookup class wrong");

  chk_tbase_lookup: assert property (
    (vec_sel_i == 8'h2F) |=> seq_lookup_source)
    else $error("Time base vector lookup class wrong");

  chk_rsvd_b_slot: assert property (
    (vec_sel_i >= 8'h30) && (vec_sel_i <= 8'h3E) |=> seq_lookup_rsvd_slot)
    else $error("Reserved vector 48-62 lookup class wrong");

  chk_delay_lookup: assert property (
    (vec_sel_i == 8'h3F) |=> seq_lookup_source)
    else $error("Delayed source vector lookup class wrong");

  chk_rtos_quiet: assert property (
    (vec_sel_i == 8'h40) || (vec_sel_i == 8'h41) |=> seq_lookup_none)
    else $error("Kernel reserved vector marked hardware");

  // Whole table, any base and any vector
  chk_entry_addr: assert property (
    1'b1 |=> vec_fetch_addr_o ==
      $past(vector_table_base_i) + 32'h3FC - {22'h0, $past(vec_sel_i), 2'b00})
    else $error("Entry address not base plus 3FC minus 4n");

  // Slot winners carry the forced top level bit and are never disabled
  chk_slot_level: assert property (
    irq_valid_o && (irq_vector_o != 8'h0F) |-> irq_level_o[4] && (irq_level_o != 5'h1F))
    else $error("Slot winner level out of range");

  chk_nmi_wins: assert property (
    nmi_req_i && (src_req_i != '0) |=> seq_nmi_shown)
    else $error("NMI did not win over slot request");

endmodule

// >>> dv/ivm_core_model.sv
// Processor core stand-in: table base and vector to fetch
module ivm_core_model (
  input  wire logic        mclk_i,
  input  wire logic        follow_i,
  input  wire logic [7:0]  sel_req_i,
  input  wire logic [31:0] base_req_i,
  input  wire logic        irq_valid_i,
  input  wire logic [7:0]  irq_vector_i,
  output logic      [7:0]  sel_o,
  output logic      [31:0] base_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] win;
  logic       take;
  initial begin
    sel_o = 8'h00;
    base_o = 32'h000F_FC00;
  end
  always @(posedge mclk_i) begin
    win = irq_vector_i;
    take = follow_i && (irq_valid_i === 1'b1);
    #1;
    sel_o = take ? win : sel_req_i;
    base_o = base_req_i;
  end
endmodule

// >>> dv/testbench.sv
// Self-checking bench for the interrupt vector map
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic         mclk_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         nmi_req_i = 1'b0;
  logic [47:0]  src_req_i = '0;
  logic [239:0] level_slot_i = '0;
  logic         follow = 1'b0;
  logic [7:0]   sel_req = 8'h00;
  logic [31:0]  base_req = 32'h000F_FC00;
  logic [31:0]  base_w, addr_w;
  logic [7:0]   sel_w, vec_w;
  logic [4:0]   lvl_w;
  logic         valid_w, hw_w, slot_w;
  int           n_fail = 0;
  int           n_checks = 0;
  int           cyc = 0;
  always #50 mclk_i = ~mclk_i;
  ivm_core_model i_ivm_core_model (.mclk_i(mclk_i), .follow_i(follow), .sel_req_i(sel_req),
    .base_req_i(base_req), .irq_valid_i(valid_w), .irq_vector_i(vec_w), .sel_o(sel_w),
    .base_o(base_w));
  ivm_top i_ivm_top (.mclk_i(mclk_i), .rst_i(rst_i), .vector_table_base_i(base_w),
    .nmi_req_i(nmi_req_i), .src_req_i(src_req_i), .level_slot_i(level_slot_i),
    .vec_sel_i(sel_w), .irq_valid_o(valid_w), .irq_vector_o(vec_w), .irq_level_o(lvl_w),
    .vec_fetch_addr_o(addr_w), .vec_hw_o(hw_w), .vec_has_slot_o(slot_w));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  function automatic logic exp_hw(input int n);
    return n == 15 || (n >= 16 && n <= 39) || (n >= 44 && n <= 47) || n == 63;
  endfunction
  task automatic t_reset;
    step(8);
    chk("valid", 32'h0, {31'h0, valid_w});
    chk("level", 32'h1F, {27'h0, lvl_w});
    chk("addr", 32'h000F_FFFC, addr_w);
    rst_i = 1'b0;
    $display("test reset done");
  endtask
  // Two bases so a hard-wired base cannot pass
  task automatic t_lookup(input logic [31:0] base);
    base_req = base;
    for (int n = 0; n < 256; n++) begin
      sel_req = n[7:0];
      step(2);
      chk("fetch addr", base + 32'h3FC - 32'(4 * n), addr_w);
      chk("hw", {31'h0, exp_hw(n)}, {31'h0, hw_w});
      chk("slot", {31'h0, n >= 16 && n <= 63}, {31'h0, slot_w});
    end
    $display("test lookup done");
  endtask
  task automatic t_sources;
    for (int s = 0; s < 48; s++) level_slot_i[5*s +: 5] = 5'h03;
    for (int s = 0; s < 48; s++) begin
      src_req_i = 48'h1 << s;
      step(1);
      chk("src valid", {31'h0, exp_hw(16 + s)}, {31'h0, valid_w});
      if (exp_hw(16 + s)) begin
        chk("src vector", 32'(16 + s), {24'h0, vec_w});
        chk("src level", 32'h13, {27'h0, lvl_w});
      end
    end
    $display("test sources done");
  endtask
  task automatic t_prio;
    level_slot_i[5*9 +: 5] = 5'h07;
    level_slot_i[5*3 +: 5] = 5'h02;
    level_slot_i[5*2 +: 5] = 5'h02;
    level_slot_i[5*5 +: 5] = 5'h0F;
    src_req_i = 48'h0;
    src_req_i[5] = 1'b1;
    step(1);
    chk("disabled slot", 32'h0, {31'h0, valid_w});
    src_req_i[9] = 1'b1;
    src_req_i[3] = 1'b1;
    src_req_i[2] = 1'b1;
    follow = 1'b1;
    step(1);
    chk("win vector", 32'h12, {24'h0, vec_w});
    chk("win level", 32'h12, {27'h0, lvl_w});
    step(2);
    chk("win fetch", base_req + 32'h3B4, addr_w);
    nmi_req_i = 1'b1;
    step(1);
    chk("nmi vector", 32'h0F, {24'h0, vec_w});
    chk("nmi level", 32'h0F, {27'h0, lvl_w});
    nmi_req_i = 1'b0;
    src_req_i = 48'h0;
    step(1);
    chk("idle", 32'h0, {31'h0, valid_w});
    $display("test priority done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Ceiling well above the roughly 1100 cycles used
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      results();
    end
  end
  initial begin
    t_reset();
    t_lookup(32'h000F_FC00);
    t_lookup(32'h0010_0400);
    t_sources();
    t_prio();
    results();
  end
endmodule
